// ### dv/tb_ios_osc_ctrl.sv
// self-checking bench for the internal oscillator select and trim block
// assumes ios_pkg compiled first; bench drives every port directly
`timescale 1ns/1ps
module tb_ios_osc_ctrl;
    import ios_pkg::*;
    logic sys_clk = 0, rst = 1, clk_en = 0, trim_wr = 0, sel_wr = 0, pll_en = 0, lf_req = 0;
    logic [TRIM_W-1:0] trim_wd = 0, trim_q;
    logic [SEL_W-1:0] sel_wd = 0, sel_q;
    logic [1:0] ss = 0;
    logic [2:0] cfg = 0;
    logic ready, hf, lf, sys, pll;
    int fails = 0, check_count = 0, n_hf, n_lf, n_sys;
    ios_osc_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .trim_wr(trim_wr),
        .trim_wdata(trim_wd), .sel_wr(sel_wr), .sel_wdata(sel_wd),
        .system_clock_source_select(ss), .config_osc_select(cfg), .pll_enable(pll_en),
        .lf_timer_req(lf_req), .osc_trim_value(trim_q), .internal_freq_select(sel_q),
        .low_freq_ready_flag(ready), .high_freq_tick(hf), .low_freq_tick(lf),
        .sys_osc_tick(sys), .pll_active(pll));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_range(input longint got, input longint lo, input longint hi, input string what);
        check_count++;
        if (got < lo || got > hi) begin
            fails++;
            $display("unexpected at %0t: %s got %0d want %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", fails, check_count);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr_trim(input logic [TRIM_W-1:0] v);
        @(posedge sys_clk);
        trim_wr <= 1'b1;
        trim_wd <= v;
        @(posedge sys_clk);
        trim_wr <= 1'b0;
        @(negedge sys_clk);
        chk_bits({2'b00, trim_q}, {2'b00, v}, "trim readback");
    endtask
    task automatic wr_sel(input logic [SEL_W-1:0] v);
        @(posedge sys_clk);
        sel_wr <= 1'b1;
        sel_wd <= v;
        @(posedge sys_clk);
        sel_wr <= 1'b0;
        @(negedge sys_clk);
        chk_bits({4'h0, sel_q}, {4'h0, v}, "select readback");
    endtask
    task automatic measure(input int n);
        n_hf = 0;
        n_lf = 0;
        n_sys = 0;
        repeat (n) begin
            @(negedge sys_clk);
            n_hf += int'(hf === 1'b1);
            n_lf += int'(lf === 1'b1);
            n_sys += int'(sys === 1'b1);
        end
    endtask
    task automatic wait_ready(input logic exp, input int lim);
        int i;
        for (i = 0; i < lim && ready !== exp; i++) begin
            @(negedge sys_clk);
        end
        chk_bits({7'h00, ready}, {7'h00, exp}, "low ready flag");
    endtask
    task automatic t_reset();
        chk_bits({2'b00, trim_q}, {2'b00, TRIM_RESET}, "trim at reset");
        chk_bits({4'h0, sel_q}, {4'h0, SEL_RESET}, "select at reset");
        chk_bits({6'h00, ready, pll}, 8'h00, "flags at reset");
    endtask
    // trim extremes: high source moves, low source keeps its rate
    task automatic t_trim();
        logic [TRIM_W-1:0] codes [2] = '{TRIM_MAX_UP, TRIM_MAX_DOWN};
        longint e_hf, e_lf;
        lf_req <= 1'b1;
        foreach (codes[k]) begin
            wr_trim(codes[k]);
            repeat (64 * SLEW_CYC) @(negedge sys_clk);
            measure(8064);
            e_hf = (longint'(8064) * (longint'(HF_INC) + longint'($signed(codes[k]))
                * longint'(TRIM_STEP))) >>> ACC_W;
            e_lf = (longint'(8064) * longint'(LF_INC)) >> ACC_W;
            chk_range(n_hf, e_hf - 2, e_hf + 2, "trimmed high rate");
            chk_range(n_lf, e_lf - 1, e_lf + 1, "low rate under trim");
        end
        lf_req <= 1'b0;
        wr_trim(TRIM_RESET);
        wait_ready(1'b0, 10);
        repeat (33 * SLEW_CYC) @(negedge sys_clk);
    endtask
    // every high-source code divides the base by its table shift
    task automatic t_sel();
        logic [3:0] sh;
        ss <= 2'b10;
        for (int c = 2; c < 16; c++) begin
            sh = ROUTE_TABLE[c*4 +: 4];
            wr_sel(SEL_W'(c));
            measure(1024);
            chk_range(n_sys, (n_hf >> sh) - 1, (n_hf >> sh) + 1, "postscaled rate");
        end
        pll_en <= 1'b1;
        measure(4);
        chk_bits({7'h00, pll}, 8'h00, "no pll off 16 MHz code");
        wr_sel(4'hE);
        measure(4);
        chk_bits({7'h00, pll}, 8'h01, "pll on 8 MHz code");
        measure(1024);
        chk_range(n_sys, 2 * n_hf - 2, 2 * n_hf + 2, "pll doubles the base rate");
        pll_en <= 1'b0;
        ss <= 2'b00;
        measure(512);
        chk_range(n_sys, 0, 0, "no system ticks off internal");
    endtask
    task automatic t_low();
        wr_sel(SEL_LF_ONLY);
        ss <= 2'b10;
        wait_ready(1'b1, 9000);
        ss <= 2'b00;
        wait_ready(1'b0, 10);
        wr_sel(4'h1);
        cfg <= CFG_INTERNAL;
        wait_ready(1'b1, 9000);
        cfg <= 3'h0;
        wait_ready(1'b0, 10);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        t_reset();
        rst <= 1'b0;
        clk_en <= 1'b1;
        t_trim();
        t_sel();
        t_low();
        final_report();
    end
    // longest path is about 62k cycles
    initial begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        final_report();
    end
endmodule

// ### rtl/ios_osc_ctrl.sv
// internal oscillator select, trim, postscaler and low-frequency source
// assumes control inputs come from logic on sys_clk (no synchronisers)
// and that ticks are used as clock enables by the core and timers
//
// Functional notes
// - trim value is a signed six-bit two's complement offset on base
// - trim register resets to zero, base runs at calibrated rate
// - 1Fh gives largest upward shift, 20h the largest downward shift
// - trim shifts the high source and the PLL together via the base
// - trim moves gradually while running; no completion flag exists
// - trim never affects the low-frequency source
// - uncalibrated 31 kHz low source times power-up, watchdog, monitor
// - low source enabled when select is 000 and source select is 1x
// - low source also enabled for low select with config 100
// - read-only ready flag is high once the running low source has produced its first tick
// - 16 MHz and 31 kHz feed postscaler and mux under four-bit select
// - high outputs are 16 MHz halved down to 31.25 kHz
// - 32 MHz only via four-times PLL on the 8 MHz output
// - every reset loads select with 0111, giving 500 kHz
// - several select codes share one table value and so give the same frequency
`timescale 1ns/1ps
module ios_osc_ctrl import ios_pkg::*; #(
    parameter logic [63:0] ROUTE_MAP = ROUTE_TABLE
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // software control
    input wire logic trim_wr,
    input wire logic [TRIM_W-1:0] trim_wdata,
    input wire logic sel_wr,
    input wire logic [SEL_W-1:0] sel_wdata,
    input wire logic [1:0] system_clock_source_select,
    input wire logic [2:0] config_osc_select,
    input wire logic pll_enable,
    input wire logic lf_timer_req,
    // status
    output logic [TRIM_W-1:0] osc_trim_value,
    output logic [SEL_W-1:0] internal_freq_select,
    output logic low_freq_ready_flag,
    // clock ticks and pll status
    output logic high_freq_tick,
    output logic low_freq_tick,
    output logic sys_osc_tick,
    output logic pll_active
);
    typedef struct packed {
        logic [TRIM_W-1:0] trim_target;
        logic signed [TRIM_W-1:0] trim_applied;
        logic [7:0] slew_cnt;
        logic [SEL_W-1:0] sel;
        logic [ACC_W-1:0] hf_acc;
        logic [ACC_W-1:0] pll_acc;
        logic [ACC_W-1:0] lf_acc;
        logic [POST_W-1:0] post_cnt;
        logic lf_en;
        logic lf_ready;
        logic hf_tick;
        logic lf_tick;
        logic osc_tick;
        logic pll_on;
    } ios_state_t;

    ios_state_t s_reg;
    ios_state_t s_next;

    logic signed [INC_W-1:0] hf_inc;
    logic signed [INC_W-1:0] pll_inc;
    logic [ACC_W:0] hf_sum;
    logic [ACC_W:0] pll_sum;
    logic [ACC_W:0] lf_sum;
    logic [3:0] route;
    logic [POST_W-1:0] post_mask;
    logic post_hit;
    logic lf_want;

    always_comb begin
        s_next = s_reg;
        // trim is signed: 1Fh pushes hardest up, 20h hardest down
        hf_inc = HF_INC + TRIM_STEP * INC_W'(s_reg.trim_applied);
        pll_inc = INC_W'(hf_inc <<< 1);
        hf_sum = {1'b0, s_reg.hf_acc} + {1'b0, hf_inc[ACC_W-1:0]};
        pll_sum = {1'b0, s_reg.pll_acc} + {1'b0, pll_inc[ACC_W-1:0]};
        // low source has a fixed step, no trim term in it
        lf_sum = {1'b0, s_reg.lf_acc} + {1'b0, LF_INC};
        route = ROUTE_MAP[4*s_reg.sel +: 4];
        post_mask = POST_W'((10'h001 << route) - 10'h001);
        post_hit = (s_reg.post_cnt & post_mask) == post_mask;
        lf_want = (s_reg.sel == SEL_LF_ONLY && system_clock_source_select[1])
            || (route == ROUTE_LF && config_osc_select == CFG_INTERNAL)
            || lf_timer_req;

        if (trim_wr) begin
            s_next.trim_target = trim_wdata;
        end
        if (sel_wr) begin
            s_next.sel = sel_wdata;
        end

        // applied trim walks one code per slew period; nothing reports arrival
        if (s_reg.trim_applied != signed'(s_reg.trim_target)) begin
            if (s_reg.slew_cnt == 8'h00) begin
                s_next.slew_cnt = 8'(SLEW_CYC - 1);
                if (s_reg.trim_applied < signed'(s_reg.trim_target)) begin
                    s_next.trim_applied = s_reg.trim_applied + 6'sh01;
                end else begin
                    s_next.trim_applied = s_reg.trim_applied - 6'sh01;
                end
            end else begin
                s_next.slew_cnt = s_reg.slew_cnt - 8'h01;
            end
        end else begin
            s_next.slew_cnt = 8'(SLEW_CYC - 1);
        end

        // base feeds the high source and the PLL alike
        s_next.hf_acc = hf_sum[ACC_W-1:0];
        s_next.hf_tick = hf_sum[ACC_W];
        s_next.pll_acc = pll_sum[ACC_W-1:0];
        if (hf_sum[ACC_W]) begin
            s_next.post_cnt = s_reg.post_cnt + 9'h001;
        end

        s_next.lf_en = lf_want;
        if (s_reg.lf_en) begin
            s_next.lf_acc = lf_sum[ACC_W-1:0];
            s_next.lf_tick = lf_sum[ACC_W];
        end else begin
            s_next.lf_acc = '0;
            s_next.lf_tick = 1'b0;
        end
        // ready only once a real low tick has been produced
        if (!s_reg.lf_en) begin
            s_next.lf_ready = 1'b0;
        end else if (s_reg.lf_tick) begin
            s_next.lf_ready = 1'b1;
        end

        // 32 MHz only when the 8 MHz tap is chosen and the PLL is on
        s_next.pll_on = pll_enable && route == SHIFT_PLL;
        s_next.osc_tick = 1'b0;
        if (system_clock_source_select[1]) begin
            if (route == ROUTE_LF) begin
                s_next.osc_tick = s_reg.lf_tick;
            end else if (s_reg.pll_on) begin
                s_next.osc_tick = pll_sum[ACC_W];
            end else begin
                s_next.osc_tick = s_reg.hf_tick && post_hit;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.trim_target <= TRIM_RESET;
            s_reg.trim_applied <= signed'(TRIM_RESET);
            s_reg.sel <= SEL_RESET;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign osc_trim_value = s_reg.trim_target;
    assign internal_freq_select = s_reg.sel;
    assign low_freq_ready_flag = s_reg.lf_ready;
    assign high_freq_tick = s_reg.hf_tick;
    assign low_freq_tick = s_reg.lf_tick;
    assign sys_osc_tick = s_reg.osc_tick;
    assign pll_active = s_reg.pll_on;

    localparam int SLEW_BOUND = 126;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !clk_en);

    sequence trim_written;
        trim_wr ##1 1'b1;
    endsequence

    sequence lf_started;
        s_reg.lf_en && s_reg.lf_tick;
    endsequence

    a_trim_load: assert property (
        trim_written |-> osc_trim_value == $past(trim_wdata))
        else $error("trim register did not take written value");

    a_sel_reset_val: assert property (
        $past(rst) |-> internal_freq_select == SEL_RESET)
        else $error("select not 0111 after reset");

    a_trim_one_step: assert property (
        $changed(s_reg.trim_applied) |->
            (s_reg.trim_applied - $past(s_reg.trim_applied) == 6'sh01)
            || ($past(s_reg.trim_applied) - s_reg.trim_applied == 6'sh01))
        else $error("applied trim jumped by more than one code");

    a_trim_moves: assert property (
        (s_reg.trim_applied != signed'(s_reg.trim_target)) && !trim_wr |->
            ##[1:SLEW_BOUND] $changed(s_reg.trim_applied))
        else $error("applied trim stalled");

    a_lf_fixed_step: assert property (
        s_reg.lf_en && $past(s_reg.lf_en) && !$past(s_reg.lf_tick) && !s_reg.lf_tick |->
            s_reg.lf_acc == $past(s_reg.lf_acc) + LF_INC)
        else $error("low source step not fixed");

    a_lf_sel_enable: assert property (
        internal_freq_select == SEL_LF_ONLY && system_clock_source_select[1] |=> s_reg.lf_en)
        else $error("low source not enabled for select 000");

    a_lf_cfg_enable: assert property (
        route == ROUTE_LF && config_osc_select == CFG_INTERNAL |=> s_reg.lf_en)
        else $error("low source not enabled by config 100");

    a_lf_ready_flag: assert property (
        lf_started |=> low_freq_ready_flag || !s_reg.lf_en)
        else $error("ready flag missing while low source runs");

    a_ready_needs_lf: assert property (
        low_freq_ready_flag |-> $past(s_reg.lf_en))
        else $error("ready flag set with low source off");

    a_pll_tap: assert property (
        pll_active |-> $past(route) == SHIFT_PLL && $past(pll_enable))
        else $error("pll active off the 8 MHz tap");

    a_hf_direct: assert property (
        system_clock_source_select[1] && route == 4'h0 && !s_reg.pll_on && s_reg.hf_tick
            |=> sys_osc_tick)
        else $error("16 MHz tick not passed through");
endmodule

// ### rtl/ios_pkg.sv
// constants for the internal oscillator select and trim block
// assumes one 125 MHz system clock; the oscillators are modelled as
// phase accumulators that issue one-cycle ticks on that clock
package ios_pkg;
    localparam longint CLK_HZ = 125_000_000;
    localparam longint HF_HZ = 16_000_000;
    localparam longint LF_HZ = 31_000;
    localparam int ACC_W = 24;
    localparam int INC_W = 26;
    // accumulator steps per system clock for each source
    localparam longint HF_INC_L = (HF_HZ * (64'h0000_0001 << ACC_W)) / CLK_HZ;
    localparam longint LF_INC_L = (LF_HZ * (64'h0000_0001 << ACC_W)) / CLK_HZ;
    localparam logic signed [INC_W-1:0] HF_INC = INC_W'(HF_INC_L);
    localparam logic [ACC_W-1:0] LF_INC = ACC_W'(LF_INC_L);
    // one trim code moves the base by 1/256 of nominal
    localparam logic signed [INC_W-1:0] TRIM_STEP = INC_W'(HF_INC_L >> 8);
    localparam int TRIM_W = 6;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;
    localparam logic [TRIM_W-1:0] TRIM_MAX_UP = 6'h1F;
    localparam logic [TRIM_W-1:0] TRIM_MAX_DOWN = 6'h20;
    // time the oscillator takes per trim code while shifting
    localparam int SLEW_NS = 1000;
    localparam int CLK_NS = 8;
    localparam int SLEW_CYC = (SLEW_NS + CLK_NS - 1) / CLK_NS;
    localparam int SEL_W = 4;
    localparam logic [SEL_W-1:0] SEL_RESET = 4'h7;
    localparam logic [SEL_W-1:0] SEL_LF_ONLY = 4'h0;
    localparam int POST_W = 9;
    // table entry: postscaler shift 0..9, or ROUTE_LF for the low source
    localparam logic [3:0] ROUTE_LF = 4'hF;
    localparam logic [3:0] SHIFT_PLL = 4'h1;
    localparam logic [63:0] ROUTE_TABLE = 64'h0134_6789_5567_89FF;
    localparam logic [2:0] CFG_INTERNAL = 3'h4;
endpackage
